/* socket_ident_status_power_regs.sv */
`timescale 1ns/1ps
module socket_ident_status_power_regs #(
   parameter logic [3:0] REV_RESET = 4'h3 // arbitrary revision value
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // system control bits
   input wire logic subsystem_write_enable,
   input wire logic vcc_level_select,
   input wire logic card_is_io,
   // card pins
   input wire socket_regs_pkg::card_pins_t card_pins,
   // socket power and gating
   output socket_regs_pkg::power_out_t power_out
);
   import socket_regs_pkg::*;

   logic [1:0] id_spare_q;
   logic [3:0] rev_q;
   logic [7:0] power_q;
   card_pins_t pins_s1_q;
   card_pins_t pins_s2_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic legacy_mode;
   logic card_seated;
   logic vcc_on;
   vcc_level_t vcc_level;
   logic [1:0] vpp_code;
   logic [7:0] ident_val;
   logic [7:0] status_val;
   logic [7:0] power_val;
   logic [7:0] rdata_d;
   logic hit_ident;
   logic hit_status;
   logic hit_power;
   power_out_t power_q_out;

   // address decode
   assign hit_ident = (reg_addr == OFS_IDENT);
   assign hit_status = (reg_addr == OFS_STATUS);
   assign hit_power = (reg_addr == OFS_POWER);

   // pin synchroniser
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins_s1_q <= '0;
         pins_s2_q <= '0;
      end else begin
         pins_s1_q <= card_pins;
         pins_s2_q <= pins_s1_q;
      end
   end

   // identification storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         id_spare_q <= ID_SPARE_RESET;
         rev_q <= REV_RESET;
      end else if (reg_wr && hit_ident && subsystem_write_enable) begin
         id_spare_q <= reg_wdata[ID_SPARE_HI:ID_SPARE_LO];
         rev_q <= reg_wdata[ID_REV_HI:ID_REV_LO];
      end
   end

   // power control storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_q <= POWER_RESET;
      end else if (reg_wr && hit_power) begin
         power_q <= reg_wdata;
      end
   end

   // layout and power decision
   assign legacy_mode = (rev_q == LEGACY_REV_CODE);
   assign card_seated = !pins_s2_q.cd1_n && !pins_s2_q.cd2_n;

   always_comb begin
      vcc_on = 1'b0;
      vcc_level = VCC_OFF;
      if (legacy_mode) begin
         if (power_q[PW_VCC_EN] && (!power_q[PW_AUTO] || card_seated)) begin
            vcc_on = 1'b1;
            vcc_level = vcc_level_select ? VCC_3V3 : VCC_5V;
         end
      end else begin
         case (power_q[PW_VCC_HI:PW_VCC_LO])
            VCC_REQ_5V: begin
               vcc_on = 1'b1;
               vcc_level = VCC_5V;
            end
            VCC_REQ_3V3: begin
               vcc_on = 1'b1;
               vcc_level = VCC_3V3;
            end
            default: begin
               vcc_on = 1'b0;
               vcc_level = VCC_OFF;
            end
         endcase
      end
   end

   always_comb begin
      vpp_code = VPP_NONE;
      if (vcc_on) begin
         vpp_code = power_q[PW_VPP_HI:PW_VPP_LO];
      end
   end

   // read values
   assign ident_val = {INTERFACE_KIND_VALUE, id_spare_q, rev_q};
   assign status_val = {1'b0,
                        vcc_on,
                        pins_s2_q.ready,
                        pins_s2_q.wp,
                        !pins_s2_q.cd2_n,
                        !pins_s2_q.cd1_n,
                        pins_s2_q.bvd2_spkr,
                        pins_s2_q.bvd1_stschg};
   assign power_val = power_q &
                      (legacy_mode ? LEGACY_READ_MASK : ALT_READ_MASK);

   always_comb begin
      rdata_d = 8'h00;
      if (hit_ident) begin
         rdata_d = ident_val;
      end else if (hit_status) begin
         rdata_d = status_val;
      end else if (hit_power) begin
         rdata_d = power_val;
      end
   end

   // registered read answer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // registered socket outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_q_out <= '0;
      end else begin
         power_q_out.output_gate <= power_q[PW_GATE];
         power_q_out.vcc_on <= vcc_on;
         power_q_out.vcc_level <= vcc_level;
         power_q_out.vpp_code <= vpp_code;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign power_out = power_q_out;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_ident_read;
      reg_rd && hit_ident;
   endsequence

   sequence s_status_read;
      reg_rd && hit_status;
   endsequence

   sequence s_power_read;
      reg_rd && hit_power;
   endsequence

   sequence s_open_ident_write;
      reg_wr && hit_ident && subsystem_write_enable;
   endsequence

   property p_kind_fixed;
      s_ident_read |=> reg_rvalid && reg_rdata[7:6] == 2'b10;
   endproperty
   a_kind_fixed: assert property (p_kind_fixed)
      else $error("identification kind bits not 10b");

   property p_ident_locked;
      reg_wr && hit_ident && !subsystem_write_enable
         |=> $stable({id_spare_q, rev_q});
   endproperty
   a_ident_locked: assert property (p_ident_locked)
      else $error("identification changed while locked");

   property p_spare_store;
      s_open_ident_write ##1 (reg_rd && hit_ident && !reg_wr)
         |=> reg_rdata[5:4] == $past(reg_wdata[5:4], 2);
   endproperty
   a_spare_store: assert property (p_spare_store)
      else $error("spare identification bits not stored");

   property p_legacy_select;
      s_open_ident_write and (reg_wdata[3:0] == 4'h2)
         |=> legacy_mode;
   endproperty
   a_legacy_select: assert property (p_legacy_select)
      else $error("legacy model not selected");

   property p_layout_follows_rev;
      s_power_read |=> reg_rdata == (($past(rev_q) == 4'h2) ?
         ($past(power_q) & 8'hb3) : ($past(power_q) & 8'h9b));
   endproperty
   a_layout_follows_rev: assert property (p_layout_follows_rev)
      else $error("layout disagrees with revision");

   property p_status_top;
      s_status_read |=> reg_rdata[7] == 1'b0
         && reg_rdata[6] == $past(vcc_on);
   endproperty
   a_status_top: assert property (p_status_top)
      else $error("status bits 7-6 wrong");

   property p_power_flag;
      s_status_read ##1 reg_rvalid |-> reg_rdata[6] == power_out.vcc_on;
   endproperty
   a_power_flag: assert property (p_power_flag)
      else $error("power flag disagrees with socket power");

   property p_ready_sync;
      card_pins.ready ##1 card_pins.ready
         |=> pins_s2_q.ready;
   endproperty
   a_ready_sync: assert property (p_ready_sync)
      else $error("ready not through two stages");

   property p_detect_inverse;
      s_status_read |=> reg_rdata[3:2] ==
         ~{$past(pins_s2_q.cd2_n), $past(pins_s2_q.cd1_n)};
   endproperty
   a_detect_inverse: assert property (p_detect_inverse)
      else $error("detect bits not inverted pins");

   property p_battery_pins;
      s_status_read and !card_is_io |=> reg_rdata[1:0] ==
         {$past(pins_s2_q.bvd2_spkr), $past(pins_s2_q.bvd1_stschg)};
   endproperty
   a_battery_pins: assert property (p_battery_pins)
      else $error("battery detect bits not card pins");

   property p_io_pins;
      s_status_read and card_is_io |=> reg_rdata[1:0] ==
         {$past(pins_s2_q.bvd2_spkr), $past(pins_s2_q.bvd1_stschg)};
   endproperty
   a_io_pins: assert property (p_io_pins)
      else $error("speaker and status change bits not card pins");

   property p_legacy_reserved;
      s_power_read and legacy_mode
         |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'b00;
   endproperty
   a_legacy_reserved: assert property (p_legacy_reserved)
      else $error("legacy reserved power bits not zero");

   property p_alt_reserved;
      s_power_read and !legacy_mode
         |=> reg_rdata[6:5] == 2'b00 && reg_rdata[2] == 1'b0;
   endproperty
   a_alt_reserved: assert property (p_alt_reserved)
      else $error("alternate reserved power bits not zero");

   property p_gate;
      reg_wr && hit_power ##1 !(reg_wr && hit_power)
         |=> power_out.output_gate == $past(reg_wdata[7], 2);
   endproperty
   a_gate: assert property (p_gate)
      else $error("output gate not following power bit 7");

   property p_no_vpp_without_vcc;
      !power_out.vcc_on |-> power_out.vpp_code == 2'b00;
   endproperty
   a_no_vpp_without_vcc: assert property (p_no_vpp_without_vcc)
      else $error("vpp applied while vcc off");

   property p_auto_switch;
      legacy_mode && power_q[5] && power_q[4] && !card_seated
         |=> !power_out.vcc_on;
   endproperty
   a_auto_switch: assert property (p_auto_switch)
      else $error("vcc on with auto switch and no card");

endmodule

/* socket_regs_pkg.sv */
package socket_regs_pkg;

   // byte offsets from the socket base
   localparam logic [11:0] OFS_IDENT = 12'h800;
   localparam logic [11:0] OFS_STATUS = 12'h801;
   localparam logic [11:0] OFS_POWER = 12'h802;

   // identification and revision fields
   localparam int ID_KIND_HI = 7;
   localparam int ID_KIND_LO = 6;
   localparam int ID_SPARE_HI = 5;
   localparam int ID_SPARE_LO = 4;
   localparam int ID_REV_HI = 3;
   localparam int ID_REV_LO = 0;
   localparam logic [1:0] INTERFACE_KIND_VALUE = 2'h2;
   localparam logic [3:0] LEGACY_REV_CODE = 4'h2;
   localparam logic [1:0] ID_SPARE_RESET = 2'h0;

   // interface status fields
   localparam int ST_RSVD = 7;
   localparam int ST_POWER = 6;
   localparam int ST_READY = 5;
   localparam int ST_WP = 4;
   localparam int ST_DET2 = 3;
   localparam int ST_DET1 = 2;
   localparam int ST_BAT_HI = 1;
   localparam int ST_BAT_LO = 0;

   // power control fields
   localparam int PW_GATE = 7;
   localparam int PW_AUTO = 5;
   localparam int PW_VCC_EN = 4;
   localparam int PW_VCC_HI = 4;
   localparam int PW_VCC_LO = 3;
   localparam int PW_VPP_HI = 1;
   localparam int PW_VPP_LO = 0;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [7:0] LEGACY_READ_MASK = 8'hb3;
   localparam logic [7:0] ALT_READ_MASK = 8'h9b;

   // alternate vcc request codes
   localparam logic [1:0] VCC_REQ_5V = 2'h2;
   localparam logic [1:0] VCC_REQ_3V3 = 2'h3;

   // vpp request codes
   localparam logic [1:0] VPP_NONE = 2'h0;
   localparam logic [1:0] VPP_VCC = 2'h1;
   localparam logic [1:0] VPP_12V = 2'h2;

   typedef enum logic [1:0] {VCC_OFF, VCC_5V, VCC_3V3} vcc_level_t;

   typedef struct packed {
      logic ready;
      logic wp;
      logic cd2_n;
      logic cd1_n;
      logic bvd2_spkr;
      logic bvd1_stschg;
   } card_pins_t;

   typedef struct packed {
      logic output_gate;
      logic vcc_on;
      vcc_level_t vcc_level;
      logic [1:0] vpp_code;
   } power_out_t;

endpackage

/* card_model.sv */
`timescale 1ns/1ps
module card_model (
   // levels the card should show
   input wire socket_regs_pkg::card_pins_t want,
   input wire logic slow,
   // socket pins
   output socket_regs_pkg::card_pins_t pins
);
   import socket_regs_pkg::*;
   // pins move off the host clock, quickly or slowly
   initial begin
      pins = '0;
      forever begin
         @(want);
         if (slow) begin
            pins <= #13 want;
         end else begin
            pins <= #3 want;
         end
      end
   end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import socket_regs_pkg::*;
   localparam logic [3:0] REV = 4'h5;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic swe = 1'b0;
   logic vsel = 1'b0;
   logic is_io = 1'b0;
   logic slow = 1'b0;
   card_pins_t want = '0;
   card_pins_t pins;
   power_out_t pout;
   logic [7:0] id_m;
   logic [7:0] pw_m;
   logic [7:0] exp_q[$];
   int n_mismatch = 0;
   int check_count = 0;

   always #5 clk = ~clk;

   socket_ident_status_power_regs #(.REV_RESET(REV)) i_dut (
      .clk(clk), .resetn(resetn), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .subsystem_write_enable(swe),
      .vcc_level_select(vsel), .card_is_io(is_io), .card_pins(pins),
      .power_out(pout));

   card_model i_card (.want(want), .slow(slow), .pins(pins));

   function automatic logic legacy_f();
      return id_m[3:0] == LEGACY_REV_CODE;
   endfunction

   function automatic logic vcc_on_f();
      if (legacy_f()) begin
         return pw_m[PW_VCC_EN] && (!pw_m[PW_AUTO] || !(want.cd1_n | want.cd2_n));
      end
      return pw_m[PW_VCC_HI];
   endfunction

   function automatic logic [7:0] status_f();
      return {1'b0, vcc_on_f(), want.ready, want.wp, ~want.cd2_n,
         ~want.cd1_n, want.bvd2_spkr, want.bvd1_stschg};
   endfunction

   function automatic logic [7:0] power_f();
      return pw_m & (legacy_f() ? LEGACY_READ_MASK : ALT_READ_MASK);
   endfunction

   function automatic power_out_t pout_f();
      power_out_t p;
      p.output_gate = pw_m[PW_GATE];
      p.vcc_on = vcc_on_f();
      p.vcc_level = VCC_OFF;
      if (p.vcc_on) begin
         if (legacy_f()) begin
            p.vcc_level = vsel ? VCC_3V3 : VCC_5V;
         end else begin
            p.vcc_level = pw_m[PW_VCC_LO] ? VCC_3V3 : VCC_5V;
         end
      end
      p.vpp_code = p.vcc_on ? pw_m[1:0] : VPP_NONE;
      return p;
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pout();
      #1;
      check_count++;
      if (pout !== pout_f()) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: power out %h expected %h", $time,
            pout, pout_f());
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      if (a == OFS_IDENT && swe) id_m = {INTERFACE_KIND_VALUE, d[5:0]};
      if (a == OFS_POWER) pw_m = d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // ident write with its readback in the very next cycle
   task automatic wr_rd_ident(input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= OFS_IDENT;
      reg_wdata <= d;
      if (swe) id_m = {INTERFACE_KIND_VALUE, d[5:0]};
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back(id_m);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(exp);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   // read results against the oldest note
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: unexpected read data", $time);
         end else begin
            chk8(reg_rdata, exp_q.pop_front());
         end
      end
   end

   task automatic print_verdict();
      if (exp_q.size() != 0) n_mismatch++;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      logic [7:0] d;
      void'($urandom(32'h29df));
      id_m = {INTERFACE_KIND_VALUE, ID_SPARE_RESET, REV};
      pw_m = POWER_RESET;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd(OFS_IDENT, id_m);
      rd(OFS_POWER, 8'h00);
      chk_pout();
      rd(OFS_STATUS, status_f());
      wr(OFS_IDENT, 8'h7f);
      rd(OFS_IDENT, id_m);
      swe <= 1'b1;
      wr(OFS_IDENT, 8'h79);
      rd(OFS_IDENT, id_m);
      wr(OFS_STATUS, 8'hff);
      rd(OFS_STATUS, status_f());
      rd(12'h803, 8'h00);
      for (int i = 0; i < 64; i++) begin
         d = 8'($urandom);
         if (i[0]) d[3:0] = LEGACY_REV_CODE;
         wr_rd_ident(d);
         want <= card_pins_t'(6'($urandom));
         is_io <= 1'($urandom);
         vsel <= 1'($urandom);
         slow <= 1'($urandom);
         wr(OFS_POWER, 8'($urandom));
         repeat (5) @(posedge clk);
         chk_pout();
         rd(OFS_STATUS, status_f());
         rd(OFS_POWER, power_f());
         rd(OFS_IDENT, id_m);
      end
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      id_m = {INTERFACE_KIND_VALUE, ID_SPARE_RESET, REV};
      pw_m = POWER_RESET;
      chk_pout();
      rd(OFS_POWER, 8'h00);
      repeat (4) @(posedge clk);
      print_verdict();
   end
endmodule
